// ---- jrs_pkg.sv ----
package jrs_pkg;

    localparam int NLANE = 8;
    localparam int CNT_W = 24;
    localparam int IDX_W = 12;
    localparam int HIST_W = 31;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LOSS_EN  = 12'h311;
    localparam logic [IDX_W-1:0] IDX_DUR      = 12'h312;
    localparam logic [IDX_W-1:0] IDX_TEST_EN  = 12'h315;
    localparam logic [IDX_W-1:0] IDX_TEST_CTL = 12'h316;
    localparam logic [IDX_W-1:0] IDX_THR_LO   = 12'h317;
    localparam logic [IDX_W-1:0] IDX_THR_MID  = 12'h318;
    localparam logic [IDX_W-1:0] IDX_THR_HI   = 12'h319;
    localparam logic [IDX_W-1:0] IDX_CNT_LO   = 12'h31A;
    localparam logic [IDX_W-1:0] IDX_CNT_MID  = 12'h31B;
    localparam logic [IDX_W-1:0] IDX_CNT_HI   = 12'h31C;
    localparam logic [IDX_W-1:0] IDX_PASS     = 12'h31D;
    localparam logic [IDX_W-1:0] IDX_IRQ_ST   = 12'h330;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h331;

    // Loss enable bits
    localparam int F_EN0  = 0;
    localparam int F_EN1  = 1;
    localparam int MF_EN0 = 2;
    localparam int MF_EN1 = 3;
    localparam int LOSS_EN_W = 4;

    // Duration and test control fields
    localparam int DUR_LSB = 4;
    localparam int DUR_W   = 4;
    localparam int SEL_LSB = 4;
    localparam int SEL_W   = 3;
    localparam int PAT_LSB = 2;
    localparam int PAT_W   = 2;
    localparam int RUN_BIT = 1;
    localparam int CLR_BIT = 0;

    localparam logic [DUR_W-1:0]   DUR_RST  = 4'h0;
    localparam logic [NLANE-1:0]   PASS_RST = 8'hFF;
    localparam logic [DUR_W:0]     TMR_ONE  = 5'h01;
    localparam logic [CNT_W-1:0]   CNT_MAX  = 24'hFFFFFF;

    localparam logic [PAT_W-1:0] PAT_P7  = 2'b00;
    localparam logic [PAT_W-1:0] PAT_P15 = 2'b01;
    localparam logic [PAT_W-1:0] PAT_P31 = 2'b10;

    localparam logic [4:0] LEN_P7  = 5'h07;
    localparam logic [4:0] LEN_P15 = 5'h0F;
    localparam logic [4:0] LEN_P31 = 5'h1F;

    // Interrupt status bits
    localparam int IRQ_LOSS0 = 0;
    localparam int IRQ_LOSS1 = 1;
    localparam int IRQ_FAIL  = 2;
    localparam int IRQ_W     = 3;

    typedef enum logic [1:0] {
        CHK_IDLE  = 2'b00,
        CHK_PRIME = 2'b01,
        CHK_RUN   = 2'b10
    } jrs_chk_e;

    typedef struct packed {
        logic frame_loss;
        logic mframe_loss;
        logic sync_err;
    } jrs_dfr_s;

    typedef struct packed {
        logic [NLANE-1:0] bits;
        logic             vld;
    } jrs_lanes_s;

    typedef struct packed {
        jrs_chk_e          st;
        logic [HIST_W-1:0] hist;
        logic [4:0]        prime;
        logic [CNT_W-1:0]  cnt;
    } jrs_chk_s;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic [LOSS_EN_W-1:0] loss_en;
        logic [DUR_W-1:0]     dur;
        logic [NLANE-1:0]     test_en;
        logic [SEL_W-1:0]     lane_sel;
        logic [PAT_W-1:0]     pat;
        logic                 run;
        logic                 clear;
        logic [CNT_W-1:0]     thr;
        logic [DUR_W:0]       tmr0;
        logic [DUR_W:0]       tmr1;
        logic                 sync0_n;
        logic                 sync1_n;
        logic [1:0]           loss_d;
        logic [NLANE-1:0]     pass_d;
        logic [IRQ_W-1:0]     irq_st;
        logic [IRQ_W-1:0]     irq_mask;
        logic                 irq;
    } jrs_top_s;

endpackage

// ---- jrs_lane_chk.sv ----
`timescale 1ns/1ps
module jrs_lane_chk (
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    input  wire logic                          en,
    input  wire logic                          clear,
    input  wire logic [jrs_pkg::PAT_W-1:0]     pat,
    input  wire logic                          rx_bit,
    input  wire logic                          rx_vld,
    input  wire logic [jrs_pkg::CNT_W-1:0]     thr,
    output logic      [jrs_pkg::CNT_W-1:0]     err_cnt,
    output logic                               pass
);
    import jrs_pkg::*;

    jrs_chk_s st;
    jrs_chk_s nx;

    // Self-synchronising check: predict each bit from the received history
    function automatic logic tap(input logic [PAT_W-1:0] p,
                                 input logic [HIST_W-1:0] h);
        unique case (p)
            PAT_P7:  tap = h[5] ^ h[6];
            PAT_P15: tap = h[13] ^ h[14];
            default: tap = h[27] ^ h[30];
        endcase
    endfunction

    function automatic logic [4:0] plen(input logic [PAT_W-1:0] p);
        unique case (p)
            PAT_P7:  plen = LEN_P7;
            PAT_P15: plen = LEN_P15;
            default: plen = LEN_P31;
        endcase
    endfunction

    always_comb begin
        nx = st;
        if (clear) begin
            nx.st = CHK_IDLE;
            nx.cnt = '0;
            nx.prime = '0;
        end else if (!en || pat == 2'b11) begin
            nx.st = CHK_IDLE;
            nx.prime = '0;
        end else begin
            unique case (st.st)
                CHK_IDLE: begin
                    nx.st = CHK_PRIME;
                end
                CHK_PRIME: begin
                    if (rx_vld) begin
                        nx.hist = {st.hist[HIST_W-2:0], rx_bit};
                        nx.prime = st.prime + 5'h01;
                        if (st.prime + 5'h01 == plen(pat)) begin
                            nx.st = CHK_RUN;
                        end
                    end
                end
                CHK_RUN: begin
                    if (rx_vld) begin
                        nx.hist = {st.hist[HIST_W-2:0], rx_bit};
                        if (tap(pat, st.hist) != rx_bit
                            && st.cnt != CNT_MAX) begin
                            nx.cnt = st.cnt + 24'h000001;
                        end
                    end
                end
                default: begin
                    nx.st = CHK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '{st: CHK_IDLE, hist: '0, prime: '0, cnt: '0};
        end else begin
            st <= nx;
        end
    end

    assign err_cnt = st.cnt;
    assign pass = (st.cnt <= thr);

    idle_when_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!en && !clear) |=> st.st == CHK_IDLE && $stable(st.cnt))
        else $error("checker kept running while stopped");

endmodule

// ---- jrs_sync_prbs.sv ----
`timescale 1ns/1ps
module jrs_sync_prbs (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [13:0]                 wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    input  wire jrs_pkg::jrs_dfr_s           deframer_0,
    input  wire jrs_pkg::jrs_dfr_s           deframer_1,
    input  wire jrs_pkg::jrs_lanes_s         lanes,
    output logic                             sync_request_out_0_n,
    output logic                             sync_request_out_1_n,
    output logic                             irq
);
    import jrs_pkg::*;

    jrs_top_s st;
    jrs_top_s nx;

    logic [CNT_W-1:0] lane_cnt [NLANE];
    logic [NLANE-1:0] lane_pass;
    logic [IDX_W-1:0] idx;
    logic             wr;
    logic             loss0;
    logic             loss1;
    logic [CNT_W-1:0] sel_cnt;
    logic [31:0]      rd;

    assign idx = wb_adr_i[13:2];
    // Writes land on the edge where ack is seen, as the master expects
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack && wb_sel_i[0];
    assign sel_cnt = lane_cnt[st.lane_sel];

    // A masked loss from one deframer on one link
    function automatic logic loss_hit(input jrs_dfr_s d,
                                      input logic en_f,
                                      input logic en_mf);
        loss_hit = (d.frame_loss && en_f) || (d.mframe_loss && en_mf);
    endfunction

    // Timer load gives code+1 whole cycles, the half cycle rounded up
    function automatic logic [DUR_W:0] tmr_next(input logic err,
                                                input logic [DUR_W:0] t,
                                                input logic [DUR_W-1:0] d);
        if (err) begin
            tmr_next = {1'b0, d} + TMR_ONE;
        end else if (t != '0) begin
            tmr_next = t - TMR_ONE;
        end else begin
            tmr_next = '0;
        end
    endfunction

    assign loss0 = loss_hit(deframer_0, st.loss_en[F_EN0],
                            st.loss_en[MF_EN0]);
    assign loss1 = loss_hit(deframer_1, st.loss_en[F_EN1],
                            st.loss_en[MF_EN1]);

    genvar gi;
    generate
        for (gi = 0; gi < NLANE; gi++) begin : g_lane
            jrs_lane_chk u_chk (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .en      (st.test_en[gi] && st.run),
                .clear   (st.clear),
                .pat     (st.pat),
                .rx_bit  (lanes.bits[gi]),
                .rx_vld  (lanes.vld),
                .thr     (st.thr),
                .err_cnt (lane_cnt[gi]),
                .pass    (lane_pass[gi])
            );
        end
    endgenerate

    always_comb begin
        rd = '0;
        unique case (idx)
            IDX_LOSS_EN:  rd[LOSS_EN_W-1:0] = st.loss_en;
            IDX_DUR:      rd[DUR_LSB +: DUR_W] = st.dur;
            IDX_TEST_EN:  rd[NLANE-1:0] = st.test_en;
            IDX_TEST_CTL: begin
                rd[SEL_LSB +: SEL_W] = st.lane_sel;
                rd[PAT_LSB +: PAT_W] = st.pat;
                rd[RUN_BIT] = st.run;
                rd[CLR_BIT] = st.clear;
            end
            IDX_THR_LO:   rd[7:0] = st.thr[7:0];
            IDX_THR_MID:  rd[7:0] = st.thr[15:8];
            IDX_THR_HI:   rd[7:0] = st.thr[23:16];
            IDX_CNT_LO:   rd[7:0] = sel_cnt[7:0];
            IDX_CNT_MID:  rd[7:0] = sel_cnt[15:8];
            IDX_CNT_HI:   rd[7:0] = sel_cnt[23:16];
            IDX_PASS:     rd[NLANE-1:0] = lane_pass;
            IDX_IRQ_ST:   rd[IRQ_W-1:0] = st.irq_st;
            IDX_IRQ_MASK: rd[IRQ_W-1:0] = st.irq_mask;
            default:      rd = '0;
        endcase
    end

    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] w1c;
        ev = '0;
        w1c = '0;
        nx = st;
        nx.ack = wb_cyc_i && wb_stb_i && !st.ack;
        if (nx.ack) begin
            nx.rdata = rd;
        end
        if (wr) begin
            unique case (idx)
                IDX_LOSS_EN:  nx.loss_en = wb_dat_i[LOSS_EN_W-1:0];
                IDX_DUR:      nx.dur = wb_dat_i[DUR_LSB +: DUR_W];
                IDX_TEST_EN:  nx.test_en = wb_dat_i[NLANE-1:0];
                IDX_TEST_CTL: begin
                    nx.lane_sel = wb_dat_i[SEL_LSB +: SEL_W];
                    nx.pat = wb_dat_i[PAT_LSB +: PAT_W];
                    nx.run = wb_dat_i[RUN_BIT];
                    nx.clear = wb_dat_i[CLR_BIT];
                end
                IDX_THR_LO:   nx.thr[7:0] = wb_dat_i[7:0];
                IDX_THR_MID:  nx.thr[15:8] = wb_dat_i[7:0];
                IDX_THR_HI:   nx.thr[23:16] = wb_dat_i[7:0];
                IDX_IRQ_ST:   w1c = wb_dat_i[IRQ_W-1:0];
                IDX_IRQ_MASK: nx.irq_mask = wb_dat_i[IRQ_W-1:0];
                default:      nx.irq_mask = st.irq_mask;
            endcase
        end
        // Shared duration, separate timers per link
        nx.tmr0 = tmr_next(deframer_0.sync_err, st.tmr0, st.dur);
        nx.tmr1 = tmr_next(deframer_1.sync_err, st.tmr1, st.dur);
        nx.sync0_n = !(loss0 || nx.tmr0 != '0);
        nx.sync1_n = !(loss1 || nx.tmr1 != '0);
        nx.loss_d = {loss1, loss0};
        nx.pass_d = lane_pass;
        ev[IRQ_LOSS0] = loss0 && !st.loss_d[0];
        ev[IRQ_LOSS1] = loss1 && !st.loss_d[1];
        ev[IRQ_FAIL] = |(st.pass_d & ~lane_pass);
        // Set wins over a clear in the same cycle
        nx.irq_st = (st.irq_st & ~w1c) | ev;
        nx.irq = |(nx.irq_st & nx.irq_mask);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '{ack: 1'b0, rdata: '0, loss_en: '0, dur: DUR_RST,
                    test_en: '0, lane_sel: '0, pat: PAT_P7, run: 1'b0,
                    clear: 1'b0, thr: '0, tmr0: '0, tmr1: '0,
                    sync0_n: 1'b1, sync1_n: 1'b1, loss_d: '0,
                    pass_d: PASS_RST, irq_st: '0, irq_mask: '0, irq: 1'b0};
        end else begin
            st <= nx;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign sync_request_out_0_n = st.sync0_n;
    assign sync_request_out_1_n = st.sync1_n;
    assign irq = st.irq;

    mf_loss_1_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (deframer_1.mframe_loss && st.loss_en[MF_EN1])
        |=> !sync_request_out_1_n)
        else $error("link 1 multiframe loss did not pull sync low");

    mf_loss_0_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (deframer_0.mframe_loss && !st.loss_en[MF_EN0]
         && !deframer_0.frame_loss && st.tmr0 == '0
         && !deframer_0.sync_err) |=> sync_request_out_0_n)
        else $error("masked link 0 multiframe loss pulled sync low");

    fr_loss_1_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (deframer_1.frame_loss && st.loss_en[F_EN1])
        |=> !sync_request_out_1_n)
        else $error("link 1 frame loss did not pull sync low");

    fr_loss_0_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (deframer_0.frame_loss && st.loss_en[F_EN0])
        |=> !sync_request_out_0_n)
        else $error("link 0 frame loss did not pull sync low");

    report_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (deframer_0.sync_err && st.dur == 4'h2)
        ##1 (!deframer_0.sync_err && !loss0) [*4]
        |-> !$past(sync_request_out_0_n, 1) && sync_request_out_0_n)
        else $error("error report low time wrong on link 0");

    shared_dur_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        deframer_1.sync_err |=> st.tmr1 == {1'b0, $past(st.dur)} + TMR_ONE)
        else $error("link 1 report timer not loaded from shared duration");

    clear_cnt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st.clear |=> sel_cnt == '0 && &lane_pass)
        else $error("clear did not zero the error counters");

    rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st.ack && $past(idx) == IDX_LOSS_EN)
        |-> wb_dat_o[31:LOSS_EN_W] == '0)
        else $error("reserved bits read nonzero");

    irq_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 irq == |($past(nx.irq_st) & $past(nx.irq_mask)))
        else $error("interrupt does not follow masked status");

    report_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        deframer_0.sync_err ##1 !sync_request_out_0_n);
    lane_fail_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        st.run && !(&lane_pass));
    irq_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(irq));

endmodule

// ---- jrs_prbs_tx.sv ----
`timescale 1ns/1ps
// Far-side transmitter: one PRBS stream copied onto all eight lanes.
// Bits are wrong only where the bench asks, through flip.
module jrs_prbs_tx (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic [1:0]            pat,
    input  wire logic [7:0]            flip,
    output jrs_pkg::jrs_lanes_s        lanes
);
    import jrs_pkg::*;
    logic [30:0] hist_r;
    logic        fb;
    always_comb begin
        case (pat)
            PAT_P15: fb = hist_r[14] ^ hist_r[13];
            PAT_P31: fb = hist_r[30] ^ hist_r[27];
            default: fb = hist_r[6] ^ hist_r[5];
        endcase
    end
    // Runs without pause so the checker can lock at any time
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hist_r <= '1;
        end else begin
            hist_r <= {hist_r[29:0], fb};
        end
    end
    assign lanes = '{bits: {8{hist_r[0]}} ^ flip, vld: 1'b1};
endmodule

// ---- jrs_sync_prbs_tb_top.sv ----
`timescale 1ns/1ps
module jrs_sync_prbs_tb_top;
    import jrs_pkg::*;
    logic              clk_sys, rstn, cyc, stb, we;
    logic [13:0]       adr;
    logic [31:0]       dat_i, dat_o, q;
    logic              ack, s0_n, s1_n, irq;
    logic [3:0]        loss_v;
    logic [1:0]        serr, tx_pat;
    logic [7:0]        flip;
    jrs_dfr_s          dfr0, dfr1;
    jrs_lanes_s        lanes;
    int                mismatches, total_checks, n0, n1;
    assign dfr0 = '{loss_v[0], loss_v[2], serr[0]};
    assign dfr1 = '{loss_v[1], loss_v[3], serr[1]};
    jrs_sync_prbs dut_u (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .deframer_0(dfr0), .deframer_1(dfr1), .lanes(lanes),
        .sync_request_out_0_n(s0_n), .sync_request_out_1_n(s1_n),
        .irq(irq));
    jrs_prbs_tx tx_u (.clk_sys(clk_sys), .rstn(rstn), .pat(tx_pat),
        .flip(flip), .lanes(lanes));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    // Holds the request until ack is sampled; one idle cycle follows
    task automatic xfer(logic w, logic [11:0] idx, logic [7:0] d);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(logic [11:0] idx, logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rd(logic [11:0] idx, logic [7:0] e, string nm);
        xfer(1'b0, idx, 8'h00);
        chk(nm, {24'h000000, e}, q);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pulse_lanes(logic [7:0] m);
        flip <= m;
        tick(1);
        flip <= 8'h00;
        tick(40);
    endtask
    function automatic logic [7:0] ctl(int s, int p, int run, int clr);
        return {1'b0, 3'(s), 2'(p), 1'(run), 1'(clr)};
    endfunction
    initial begin
        mismatches = 0;
        total_checks = 0;
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
    initial begin
        rstn = 1'b0;
        {cyc, stb, we, adr, dat_i} = '0;
        {loss_v, serr, tx_pat, flip} = '0;
        tick(8);
        rstn <= 1'b1;
        rd(IDX_LOSS_EN, 8'h00, "loss_en rst");
        rd(IDX_TEST_EN, 8'h00, "test_en rst");
        rd(IDX_TEST_CTL, 8'h00, "ctl rst");
        rd(IDX_PASS, 8'hFF, "pass rst");
        rd(IDX_CNT_HI, 8'h00, "cnt hi rst");
        rd(IDX_IRQ_MASK, 8'h00, "mask rst");
        rd(12'h300, 8'h00, "unmapped");
        wr(IDX_LOSS_EN, 8'hFF);
        rd(IDX_LOSS_EN, 8'h0F, "loss_en rsvd");
        wr(IDX_DUR, 8'hFF);
        rd(IDX_DUR, 8'hF0, "dur rsvd");
        wr(IDX_TEST_CTL, 8'hFD);
        rd(IDX_TEST_CTL, 8'h7D, "ctl rsvd");
        wr(IDX_TEST_CTL, 8'h00);
        wr(IDX_THR_MID, 8'hA5);
        rd(IDX_THR_MID, 8'hA5, "thr mid");
        wr(IDX_THR_MID, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(IDX_LOSS_EN, 8'(1 << i));
            for (int j = 0; j < 4; j++) begin
                loss_v <= 4'(1 << j);
                tick(3);
                chk("sync0", {31'h0, !(i == j && j % 2 == 0)}, s0_n);
                chk("sync1", {31'h0, !(i == j && j % 2 == 1)}, s1_n);
                loss_v <= 4'h0;
                tick(3);
            end
        end
        $display("test loss masks done");
        rd(IDX_IRQ_ST, 8'h03, "irq status");
        chk("irq masked", 32'h0, irq);
        wr(IDX_IRQ_MASK, 8'h03);
        tick(1);
        chk("irq on", 32'h1, irq);
        wr(IDX_IRQ_ST, 8'h01);
        rd(IDX_IRQ_ST, 8'h02, "irq w1c");
        wr(IDX_IRQ_ST, 8'h02);
        tick(1);
        chk("irq off", 32'h0, irq);
        $display("test irq done");
        for (int k = 0; k < 3; k++) begin
            wr(IDX_DUR, k == 0 ? 8'h00 : (k == 1 ? 8'h20 : 8'hF0));
            serr <= 2'b11;
            tick(1);
            serr <= 2'b00;
            n0 = 0;
            n1 = 0;
            repeat (24) begin
                @(posedge clk_sys);
                n0 += (s0_n === 1'b0);
                n1 += (s1_n === 1'b0);
            end
            chk("low0", k == 0 ? 1 : (k == 1 ? 3 : 16), n0);
            chk("low1", k == 0 ? 1 : (k == 1 ? 3 : 16), n1);
        end
        $display("test error report done");
        wr(IDX_TEST_EN, 8'hFF);
        for (int p = 0; p < 4; p++) begin
            wr(IDX_THR_LO, p == 1 ? 8'h06 : 8'h00);
            tx_pat <= 2'(p);
            wr(IDX_TEST_CTL, ctl(3, p, 0, 1));
            wr(IDX_TEST_CTL, ctl(3, p, 1, 0));
            tick(80);
            pulse_lanes(8'h08);
            pulse_lanes(8'h08);
            rd(IDX_CNT_LO, p == 3 ? 8'h00 : 8'h06, "cnt");
            rd(IDX_PASS, p % 2 ? 8'hFF : 8'hF7, "pass");
            wr(IDX_TEST_CTL, ctl(0, p, 1, 0));
            rd(IDX_CNT_LO, 8'h00, "cnt lane0");
            wr(IDX_TEST_CTL, ctl(3, p, 0, 0));
            pulse_lanes(8'h08);
            rd(IDX_CNT_LO, p == 3 ? 8'h00 : 8'h06, "cnt held");
            rd(IDX_CNT_MID, 8'h00, "cnt mid");
            wr(IDX_TEST_CTL, ctl(3, p, 0, 1));
            rd(IDX_CNT_LO, 8'h00, "cnt clr");
            rd(IDX_PASS, 8'hFF, "pass clr");
        end
        rd(IDX_IRQ_ST, 8'h04, "irq fail");
        wr(IDX_IRQ_MASK, 8'h04);
        tick(1);
        chk("irq fail on", 32'h1, irq);
        wr(IDX_IRQ_ST, 8'h04);
        tick(1);
        chk("irq fail off", 32'h0, irq);
        $display("test prbs done");
        wr(IDX_TEST_EN, 8'hF7);
        tx_pat <= 2'b00;
        wr(IDX_TEST_CTL, ctl(3, 0, 1, 0));
        tick(80);
        pulse_lanes(8'h0C);
        rd(IDX_CNT_LO, 8'h00, "cnt gated");
        wr(IDX_TEST_CTL, ctl(2, 0, 1, 0));
        rd(IDX_CNT_LO, 8'h03, "cnt lane2");
        $display("test lane enable done");
        close_out();
    end
endmodule
